// ==== testbench/ecp_peer.sv ====
// peripheral model on the parallel lines
// assumes control levels already resolved against their pull-ups
`timescale 1ns/10ps
module ecp_peer (
    input wire logic clk,
    input wire logic rev_en,
    input wire ecp_pkg::ecp_ctl_s ctl,
    input wire logic [7:0] pd,
    input wire logic pd_oe,
    output ecp_pkg::ecp_stat_s stat,
    output logic [7:0] pd_in,
    output logic [8:0] last,
    output int n
);
    // drives its own byte whenever the host lets go of the data lines
    logic [7:0] src = 8'h30;
    assign pd_in = pd_oe ? pd : src;
    initial
    begin
        stat = 5'h0b;
        n = 0;
    end
    always @(posedge clk)
    begin
        stat.busy <= !ctl.strobe_line;
        if (!ctl.strobe_line && !stat.busy)
        begin
            last <= {ctl.auto_feed_line, pd};
            n <= n + 1;
        end
        stat.ack_n <= !(rev_en && !ctl.auto_feed_line);
        if (rev_en && ctl.auto_feed_line && !stat.ack_n)
            src <= src + 8'h01;
    end
endmodule : ecp_peer

// ==== testbench/ecp_port_ctrl_props.sv ====
// assertions on the pins of the parallel port control block
// assumes the apb master holds the address through the access phase
`timescale 1ns/10ps
`include "ecp_params.svh"
module ecp_port_ctrl_props (
    input wire logic I_CLK,
    input wire logic I_RESETN,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [12:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    input wire logic [31:0] O_PRDATA,
    input wire logic O_PREADY,
    input wire logic O_PSLVERR,
    input wire logic O_PD_OE,
    input wire ecp_pkg::ecp_ctl_s O_CTL,
    input wire ecp_pkg::ecp_ctl_s O_CTL_OE,
    input wire logic O_EPP_ACTIVE
);
    // shadow of the mode; two delayed copies tell when registered pins settled
    logic [2:0] mode;
    logic [2:0] p1;
    logic [2:0] p2;
    wire done = I_PSEL && I_PENABLE && O_PREADY;
    wire ecr = I_PADDR == {`ECP_IDX_ECR, 2'h0};
    wire [2:0] nm = I_PWDATA[7:5];
    wire steady = mode == p1 && mode == p2;
    always_ff @(posedge I_CLK)
    begin
        p1 <= I_RESETN ? mode : 3'h7;
        p2 <= I_RESETN ? p1 : 3'h7;
        if (!I_RESETN)
            mode <= 3'h0;
        else if (done && I_PWRITE && ecr && (mode < 3'h2 || nm < 3'h2))
            mode <= nm;
    end
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RESETN);
    AST_READY_ONE: assert property (O_PREADY |=> !O_PREADY)
        else $error("ready held two cycles");
    AST_ONE_WAIT: assert property ($rose(I_PENABLE) && I_PSEL |=> O_PREADY)
        else $error("no answer after one wait state");
    AST_ERR: assert property (O_PSLVERR |-> O_PREADY && O_PRDATA == 32'h0000_0000)
        else $error("error without ready or with data");
    AST_ECR_RD: assert property (done && !I_PWRITE && ecr |-> O_PRDATA[7:5] == mode && !(&O_PRDATA[1:0]))
        else $error("mode field or queue flags wrong");
    AST_STD_OC: assert property (steady && mode == 3'h0 |-> O_CTL == 4'h0 && O_PD_OE)
        else $error("standard mode drivers wrong");
    AST_PUSH_PULL: assert property (steady && mode != 3'h0 && mode != 3'h5 |-> O_CTL_OE == 4'hf)
        else $error("control drivers not push-pull");
    AST_RSV_SAFE: assert property (steady && mode == 3'h5 |-> O_CTL == 4'hf && !O_PD_OE)
        else $error("reserved mode not idle");
    AST_EPP_MODE: assert property (O_EPP_ACTIVE |-> mode == 3'h4 || p1 == 3'h4)
        else $error("epp select outside its mode");
    AST_EXIT_DROP: assert property (p1 == 3'h3 && mode < 3'h2 |-> ##[0:2] ((O_CTL.strobe_line || !O_CTL_OE.strobe_line) && (O_CTL.auto_feed_line || !O_CTL_OE.auto_feed_line)))
        else $error("handshake lines held after leaving ecp");
    COV_FULL: cover property (done && ecr && O_PRDATA[1]);
    COV_ERR: cover property (O_PSLVERR);
    COV_EPP: cover property (O_EPP_ACTIVE);
endmodule : ecp_port_ctrl_props
bind ecp_port_ctrl ecp_port_ctrl_props ecp_port_ctrl_props_i (.I_CLK(I_CLK), .I_RESETN(I_RESETN),
    .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
    .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_PD_OE(O_PD_OE), .O_CTL(O_CTL),
    .O_CTL_OE(O_CTL_OE), .O_EPP_ACTIVE(O_EPP_ACTIVE));

// ==== testbench/ecp_port_ctrl_tb.sv ====
// self-checking bench for the parallel port control block
// assumes the peripheral model answers every handshake
`timescale 1ns/10ps
`include "ecp_params.svh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_errors++; \
    $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module ecp_port_ctrl_tb;
    localparam int DEPTH = 4;
    localparam logic [12:0] A_DATA = {`ECP_IDX_DATA, 2'h0};
    localparam logic [12:0] A_DCR = {`ECP_IDX_DCR, 2'h0};
    localparam logic [12:0] A_OPT = {`ECP_IDX_OPT, 2'h0};
    localparam logic [12:0] A_Q = {`ECP_IDX_QUEUE, 2'h0};
    localparam logic [12:0] A_CFGB = {`ECP_IDX_CFGB, 2'h0};
    localparam logic [12:0] A_ECR = {`ECP_IDX_ECR, 2'h0};
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, pd_oe, epp, rev_en;
    logic [12:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0] pd_out, pd_in;
    logic [8:0] last;
    int n;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    ecp_pkg::ecp_stat_s stat;
    ecp_pkg::ecp_ctl_s ctl, ctl_oe, ctl_w;
    assign ctl_w = ctl | ~ctl_oe;
    ecp_port_ctrl #(.DEPTH(DEPTH)) ecp_port_ctrl_i (.I_CLK(clk), .I_RESETN(rst_n), .I_PSEL(psel),
        .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(pslverr), .I_PD(pd_in), .O_PD(pd_out), .O_PD_OE(pd_oe), .I_STAT(stat),
        .O_CTL(ctl), .O_CTL_OE(ctl_oe), .O_EPP_ACTIVE(epp));
    ecp_peer ecp_peer_i (.clk(clk), .rev_en(rev_en), .ctl(ctl_w), .pd(pd_out), .pd_oe(pd_oe), .stat(stat),
        .pd_in(pd_in), .last(last), .n(n));
    task automatic apb(input logic w, input logic [12:0] a, input logic [7:0] d, output logic [31:0] r,
        output logic e);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge clk);
        penable <= 1'b1;
        // answer is taken at the rising edge that sees pready; only the run timeout ends a stuck wait
        do
            @(posedge clk);
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr
    task automatic rd(input logic [12:0] a, input logic [7:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 8'h00, r, e);
        `CHK({e, r}, {1'b0, 24'h00_0000, x})
    endtask : rd
    task automatic md(input logic [2:0] m);
        wr(A_ECR, {m, 5'h14});
    endtask : md
    task automatic wait_n(input int c);
        for (int k = 0; k < 2000 && n < c; k++)
            @(negedge clk);
    endtask : wait_n
    task automatic t_reset;
        logic [31:0] r;
        logic e;
        rd(A_ECR, 8'h15);
        rd(A_CFGB, 8'h00);
        apb(1'b0, 13'h0040, 8'h00, r, e);
        `CHK(e, 1'b1)
    endtask : t_reset
    task automatic t_test;
        md(`ECP_M_RSV);
        md(`ECP_M_STD);
        md(`ECP_M_TEST);
        for (int i = 0; i <= DEPTH; i++)
        begin
            if (i == DEPTH - 1)
                rd(A_ECR, 8'hd4);
            wr(A_Q, 8'(8'h40 + i));
        end
        md(`ECP_M_ECP);
        rd(A_ECR, 8'hd6);
        for (int i = 0; i < DEPTH; i++)
            rd(A_Q, 8'(8'h40 + i));
        rd(A_Q, 8'(8'h40 + DEPTH - 1));
        rd(A_ECR, 8'hd5);
        `CHK(n, 0)
        md(`ECP_M_STD);
    endtask : t_test
    task automatic t_cfg;
        logic [3:0] irq [8] = '{4'hf, 4'he, 4'hb, 4'ha, 4'h9, 4'h7, 4'h5, 4'h3};
        logic [2:0] code [8] = '{3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h7, 3'h0};
        md(`ECP_M_CFG);
        rd(A_Q, 8'h10);
        for (int i = 0; i < 8; i++)
        begin
            wr(A_OPT, {1'b0, irq[i], 3'(i)});
            rd(A_CFGB, {2'h0, code[i], i[2] ? 3'h0 : 3'(i)});
        end
        md(`ECP_M_STD);
        md(`ECP_M_EPP);
        repeat (2) @(negedge clk);
        `CHK(epp, 1'b1)
        md(`ECP_M_STD);
        wr(A_OPT, 8'h00);
        md(`ECP_M_EPP);
        repeat (2) @(negedge clk);
        `CHK(epp, 1'b0)
        md(`ECP_M_STD);
    endtask : t_cfg
    task automatic t_fwd;
        wr(A_DCR, 8'h00);
        md(`ECP_M_FIFO);
        wr(A_Q, 8'h5a);
        wait_n(1);
        `CHK(last[7:0], 8'h5a)
        md(`ECP_M_STD);
        md(`ECP_M_ECP);
        wr(A_Q, 8'ha5);
        wr(A_DATA, 8'h81);
        wait_n(2);
        `CHK(last, {1'b1, 8'ha5})
        wait_n(3);
        `CHK(last, {1'b0, 8'h81})
        md(`ECP_M_STD);
    endtask : t_fwd
    task automatic t_rev;
        wr(A_DCR, 8'h20);
        rd(A_DCR, 8'h00);
        md(`ECP_M_PS2);
        wr(A_DCR, 8'h20);
        rd(A_DCR, 8'h20);
        `CHK(pd_oe, 1'b0)
        rd(A_DATA, 8'h30);
        rev_en <= 1'b1;
        md(`ECP_M_ECP);
        repeat (40) @(negedge clk);
        rd(A_Q, 8'h30);
        md(`ECP_M_PS2);
        rev_en <= 1'b0;
        rd(A_ECR, 8'h35);
        wr(A_DCR, 8'h00);
        md(`ECP_M_STD);
    endtask : t_rev
    task automatic print_verdict;
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : print_verdict
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // a stuck handshake would otherwise hang the run
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            n_errors++;
            print_verdict();
        end
    end
    initial
    begin
        {rst_n, psel, penable, pwrite, rev_en} = 5'h00;
        paddr = 13'h0000;
        pwdata = 32'h0000_0000;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_test();
        t_cfg();
        t_fwd();
        t_rev();
        print_verdict();
    end
endmodule : ecp_port_ctrl_tb

// ==== verilog/ecp_params.svh ====
// constants for the extended parallel port control block
// assumes a 100 MHz system clock and word-aligned apb registers
`ifndef ECP_PARAMS_SVH
`define ECP_PARAMS_SVH
// register indexes, byte address is four times the index
`define ECP_IDX_DATA 11'h000
`define ECP_IDX_DSR 11'h001
`define ECP_IDX_DCR 11'h002
`define ECP_IDX_OPT 11'h003
`define ECP_IDX_QUEUE 11'h400
`define ECP_IDX_CFGB 11'h401
`define ECP_IDX_ECR 11'h402
// mode codes
`define ECP_M_STD 3'h0
`define ECP_M_PS2 3'h1
`define ECP_M_FIFO 3'h2
`define ECP_M_ECP 3'h3
`define ECP_M_EPP 3'h4
`define ECP_M_RSV 3'h5
`define ECP_M_TEST 3'h6
`define ECP_M_CFG 3'h7
// reset and fixed values
`define ECP_CFGA_VAL 8'h10
`define ECP_ECR_LO_RST 3'h5
`define ECP_OPT_RST 7'h00
`define ECP_DCR_RST 6'h00
`define ECP_DATA_RST 8'h00
// compatibility handshake setup and strobe width
`define ECP_HS_NS 500
`define ECP_CLK_MHZ 100
`define ECP_HS_CYC ((`ECP_HS_NS * `ECP_CLK_MHZ + 999) / 1000)
`endif

// ==== verilog/ecp_pkg.sv ====
// types for the extended parallel port control block
// assumes ecp_params.svh supplies the numeric constants
package ecp_pkg;
    typedef struct packed {
        logic busy;
        logic ack_n;
        logic perror;
        logic select;
        logic fault_n;
    } ecp_stat_s;
    typedef struct packed {
        logic strobe_line;
        logic auto_feed_line;
        logic initialize_line;
        logic select_in_line;
    } ecp_ctl_s;
    typedef enum logic [2:0] {
        HS_IDLE,
        HS_SETUP,
        HS_STROBE,
        HS_REL,
        HS_RACK
    } ecp_hs_e;
endpackage : ecp_pkg

// ==== verilog/ecp_port_ctrl.sv ====
// mode, queue and handshake control for an extended parallel port
// assumes an apb master on I_CLK and a 1284 peripheral on the pins
//
// Contract
// - full flag is 1 when queue has no free byte, else 0
// - empty flag is 1 only when queue holds no data
// - mode 000 resets queue, open-collector controls, data never tri-stated
// - mode 001 direction tri-states data; data read returns pin levels
// - mode 010 sends queued bytes with compatibility handshake
// - mode 011 forward merges data and address bytes, sends by ecp
// - mode 011 reverse handshakes peripheral bytes into the queue
// - mode 100 selects epp only when the epp option is enabled
// - mode 110 host writes and reads queue, nothing sent
// - mode 111 maps capability words a and b onto queue addresses
// - capability b bits 5:3 encode the selected irq
// - capability b bits 2:0 encode the selected dma channel
// - handshaking runs only in modes 010 and 011
// - from 000/001 any mode; otherwise only 000 or 001
// - direction bit changes only in mode 001
// - leaving forward transfer deasserts controls with the switch
// - leaving ecp reverse discards collected bytes
// - leaving reverse drops the auto feed request at once
// - address bytes via address queue, forward only; data via data queue
// - ecr bits 7:5 are read/write mode select
//
// Decided for this implementation: register access over APB.
`timescale 1ns/10ps
`include "ecp_params.svh"

module ecp_port_ctrl #(
    parameter int DEPTH = 16
)
(
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_RESETN,
    // apb slave
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [12:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    // parallel data lines
    input wire logic [7:0] I_PD,
    output logic [7:0] O_PD,
    output logic O_PD_OE,
    // peripheral status lines
    input wire ecp_pkg::ecp_stat_s I_STAT,
    // control lines, enable high while driving
    output ecp_pkg::ecp_ctl_s O_CTL,
    output ecp_pkg::ecp_ctl_s O_CTL_OE,
    // epp engine select
    output logic O_EPP_ACTIVE
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);
    localparam logic [9:0] HS_CYC = 10'(`ECP_HS_CYC);

    function automatic logic [2:0] irq_code(input logic [3:0] irq);
        unique case (irq)
            4'hf: irq_code = 3'h6;
            4'he: irq_code = 3'h5;
            4'hb: irq_code = 3'h4;
            4'ha: irq_code = 3'h3;
            4'h9: irq_code = 3'h2;
            4'h7: irq_code = 3'h1;
            4'h5: irq_code = 3'h7;
            default: irq_code = 3'h0;
        endcase
    endfunction : irq_code

    function automatic logic is_mode(input logic [2:0] m, input logic [2:0] code);
        is_mode = (m == code);
    endfunction : is_mode

    // pin synchronisers, first stage read only by the second
    // the engine therefore sees busy and ack two cycles after the pins move
    logic [12:0] sync1;
    logic [12:0] sync2;
    always_ff @(posedge I_CLK)
    begin
        sync1 <= {I_PD, I_STAT};
        sync2 <= sync1;
    end
    wire [7:0] pin_pd = sync2[12:5];
    ecp_pkg::ecp_stat_s st;
    assign st = ecp_pkg::ecp_stat_s'(sync2[4:0]);

    // software registers
    logic [7:0] data_latch;
    logic [5:0] dcr;
    logic [2:0] mode;
    logic [2:0] ecr_lo;
    logic [6:0] opt;
    logic [7:0] last_rd;

    // apb decode
    wire [10:0] idx = I_PADDR[12:2];
    wire setup_acc = I_PSEL & I_PENABLE & ~O_PREADY;
    wire done = I_PSEL & I_PENABLE & O_PREADY;
    wire hit_data = idx == `ECP_IDX_DATA;
    wire hit_dsr = idx == `ECP_IDX_DSR;
    wire hit_dcr = idx == `ECP_IDX_DCR;
    wire hit_opt = idx == `ECP_IDX_OPT;
    wire hit_queue = idx == `ECP_IDX_QUEUE;
    wire hit_cfgb = idx == `ECP_IDX_CFGB;
    wire hit_ecr = idx == `ECP_IDX_ECR;
    wire mapped = hit_data | hit_dsr | hit_dcr | hit_opt | hit_queue | hit_cfgb | hit_ecr;
    wire wr = done & I_PWRITE;
    wire rd_acc = setup_acc & ~I_PWRITE;

    // mode decode
    wire m_std = is_mode(mode, `ECP_M_STD);
    wire m_ps2 = is_mode(mode, `ECP_M_PS2);
    wire m_fifo = is_mode(mode, `ECP_M_FIFO);
    wire m_ecp = is_mode(mode, `ECP_M_ECP);
    wire m_epp = is_mode(mode, `ECP_M_EPP);
    wire m_rsv = is_mode(mode, `ECP_M_RSV);
    wire m_test = is_mode(mode, `ECP_M_TEST);
    wire m_cfg = is_mode(mode, `ECP_M_CFG);
    wire fwd = ~dcr[5];
    wire xfer_fwd = m_fifo | (m_ecp & fwd);
    wire xfer_rev = m_ecp & ~fwd;
    wire [2:0] new_mode = I_PWDATA[7:5];
    wire new_low = is_mode(new_mode, `ECP_M_STD) | is_mode(new_mode, `ECP_M_PS2);
    // a refused mode write still stores ecr bits 4:2; only the mode field is kept
    wire mode_ok = m_std | m_ps2 | new_low;
    wire mode_wr = wr & hit_ecr & mode_ok & (new_mode != mode);
    wire drop_low = mode_wr & new_low;

    // queue storage
    logic [8:0] mem [DEPTH];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    wire full = cnt == FULL_CNT;
    wire empty = cnt == '0;
    wire [8:0] head = mem[rp];

    // handshake engine
    ecp_pkg::ecp_hs_e hs;
    ecp_pkg::ecp_hs_e next_hs;
    // one timer serves setup, strobe and release; it reloads on every state change
    logic [9:0] tmr;
    logic [8:0] out_byte;
    wire tmr_done = tmr == '0;
    wire eng_run = xfer_fwd | xfer_rev;
    wire eng_pop = xfer_fwd & (hs == ecp_pkg::HS_IDLE) & ~empty & ~st.busy;
    wire eng_push = xfer_rev & (hs == ecp_pkg::HS_IDLE) & ~st.ack_n & ~full;
    wire strobe_end = m_fifo ? tmr_done : st.busy;
    wire rel_end = m_fifo ? tmr_done : ~st.busy;

    always_comb
    begin
        next_hs = hs;
        unique case (hs)
            ecp_pkg::HS_IDLE:
            begin
                if (eng_pop)
                    next_hs = ecp_pkg::HS_SETUP;
                else if (eng_push)
                    next_hs = ecp_pkg::HS_RACK;
            end
            ecp_pkg::HS_SETUP: if (tmr_done) next_hs = ecp_pkg::HS_STROBE;
            ecp_pkg::HS_STROBE: if (strobe_end) next_hs = ecp_pkg::HS_REL;
            ecp_pkg::HS_REL: if (rel_end) next_hs = ecp_pkg::HS_IDLE;
            ecp_pkg::HS_RACK: if (st.ack_n) next_hs = ecp_pkg::HS_IDLE;
            default: next_hs = ecp_pkg::HS_IDLE;
        endcase
        if (!eng_run || mode_wr || !I_RESETN)
            next_hs = ecp_pkg::HS_IDLE;
    end

    // engine state and byte start clean so no control line shows an unknown after reset
    always_ff @(posedge I_CLK)
    begin
        if (!I_RESETN)
        begin
            hs <= ecp_pkg::HS_IDLE;
            tmr <= HS_CYC;
            out_byte <= 9'h000;
        end
        else
        begin
            hs <= next_hs;
            tmr <= (next_hs != hs) ? HS_CYC : (tmr_done ? tmr : tmr - 10'h001);
            if (eng_pop)
                out_byte <= head;
        end
    end

    // host queue access
    wire host_push = wr & hit_queue & ((m_fifo) | (m_ecp & fwd) | m_test);
    wire addr_push = wr & hit_data & m_ecp & fwd;
    wire host_pop = rd_acc & hit_queue & (m_test | xfer_rev) & ~empty;
    // a write into a full queue is dropped; software sees only the full flag
    wire push_en = (host_push | addr_push | eng_push) & ~full;
    wire pop_en = host_pop | eng_pop;
    wire [8:0] push_val = eng_push ? {1'b0, pin_pd} : {addr_push, I_PWDATA[7:0]};
    wire q_clear = m_std | drop_low;

    always_ff @(posedge I_CLK)
    begin
        if (push_en)
            mem[wp] <= push_val;
    end

    always_ff @(posedge I_CLK)
    begin
        if (!I_RESETN || q_clear)
        begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
        end
        else
        begin
            wp <= push_en ? wp + 1'b1 : wp;
            rp <= pop_en ? rp + 1'b1 : rp;
            cnt <= cnt + (AW + 1)'(push_en) - (AW + 1)'(pop_en);
        end
    end

    // register writes
    always_ff @(posedge I_CLK)
    begin
        if (!I_RESETN)
        begin
            data_latch <= `ECP_DATA_RST;
            dcr <= `ECP_DCR_RST;
            mode <= `ECP_M_STD;
            ecr_lo <= `ECP_ECR_LO_RST;
            opt <= `ECP_OPT_RST;
        end
        else if (wr)
        begin
            if (hit_data && !m_ecp)
                data_latch <= I_PWDATA[7:0];
            if (hit_dcr)
                dcr <= {m_ps2 ? I_PWDATA[5] : dcr[5], I_PWDATA[4:0]};
            if (hit_ecr && mode_ok)
                mode <= new_mode;
            if (hit_ecr)
                ecr_lo <= I_PWDATA[4:2];
            if (hit_opt)
                opt <= I_PWDATA[6:0];
        end
    end

    // test mode re-reads the last byte when the queue runs dry
    always_ff @(posedge I_CLK)
    begin
        if (!I_RESETN)
            last_rd <= 8'h00;
        else if (host_pop)
            last_rd <= head[7:0];
    end

    // read data
    wire [7:0] data_rd = m_ps2 ? pin_pd : data_latch;
    wire [7:0] dsr_rd = {~st.busy, st.ack_n, st.perror, st.select, st.fault_n, 3'h0};
    wire [7:0] cfgb_rd = {2'h0, irq_code(opt[6:3]), opt[2] ? 3'h0 : {1'b0, opt[1:0]}};
    wire [7:0] q_rd = empty ? last_rd : head[7:0];
    wire [7:0] queue_rd = m_cfg ? `ECP_CFGA_VAL : ((m_test | xfer_rev) ? q_rd : 8'h00);
    wire [7:0] ecr_rd = {mode, ecr_lo, full, empty};
    wire [7:0] rd_val = hit_data ? data_rd :
                        hit_dsr ? dsr_rd :
                        hit_dcr ? {2'h0, dcr} :
                        hit_opt ? {1'b0, opt} :
                        hit_queue ? queue_rd :
                        hit_cfgb ? (m_cfg ? cfgb_rd : 8'h00) :
                        hit_ecr ? ecr_rd : 8'h00;

    // one wait state: pready rises in the second access cycle
    always_ff @(posedge I_CLK)
    begin
        if (!I_RESETN)
        begin
            O_PREADY <= 1'b0;
            O_PSLVERR <= 1'b0;
            O_PRDATA <= 32'h0000_0000;
        end
        else
        begin
            O_PREADY <= setup_acc;
            O_PSLVERR <= setup_acc & ~mapped;
            O_PRDATA <= rd_acc ? {24'h00_0000, rd_val} : 32'h0000_0000;
        end
    end

    // line levels, dcr drives them outside the transfer modes and mode 101, which forces all four high
    ecp_pkg::ecp_ctl_s lvl;
    ecp_pkg::ecp_ctl_s next_ctl;
    ecp_pkg::ecp_ctl_s next_ctl_oe;
    wire eng_strobe_n = ~(xfer_fwd & (hs == ecp_pkg::HS_STROBE));
    wire eng_af_n = xfer_rev ? (hs == ecp_pkg::HS_RACK) : (m_fifo | ~out_byte[8]);
    always_comb
    begin
        lvl.strobe_line = eng_run ? eng_strobe_n : ~dcr[0];
        lvl.auto_feed_line = eng_run ? eng_af_n : ~dcr[1];
        lvl.initialize_line = dcr[2];
        lvl.select_in_line = ~dcr[3];
        next_ctl = lvl;
        next_ctl_oe = 4'hf;
        if (m_rsv)
            next_ctl = 4'hf;
        else if (m_std)
        begin
            next_ctl = 4'h0;
            next_ctl_oe = ~lvl;
        end
    end

    // data lines: driven in 000 and 010 whatever the direction bit
    wire next_pd_oe = (m_std | m_fifo) ? 1'b1 : (m_rsv ? 1'b0 : fwd);
    wire [7:0] next_pd = xfer_fwd ? out_byte[7:0] : (m_test ? head[7:0] : data_latch);

    always_ff @(posedge I_CLK)
    begin
        if (!I_RESETN)
        begin
            O_CTL <= 4'hf;
            O_CTL_OE <= 4'h0;
            O_PD <= 8'h00;
            O_PD_OE <= 1'b0;
            O_EPP_ACTIVE <= 1'b0;
        end
        else
        begin
            O_CTL <= next_ctl;
            O_CTL_OE <= next_ctl_oe;
            O_PD <= next_pd;
            O_PD_OE <= next_pd_oe;
            O_EPP_ACTIVE <= m_epp & opt[0];
        end
    end
endmodule : ecp_port_ctrl
